// ==== logic/irqprs_pkg.sv ====
// constants, types and layouts of the priority and reset status block
package irqprs_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int NSRC = 7;
   localparam int NEV = 5;

   localparam logic [3:0] OFF_PRIO = 4'h0;
   localparam logic [3:0] OFF_RSTC = 4'h1;
   localparam logic [3:0] OFF_IRQ_STAT = 4'h2;
   localparam logic [3:0] OFF_IRQ_MASK = 4'h3;

   localparam int PRIO_OSCF = 7;
   localparam int PRIO_CMP = 6;
   localparam int PRIO_NVM = 4;
   localparam int PRIO_BCOL = 3;
   localparam int PRIO_VDET = 2;
   localparam int PRIO_TMR3 = 1;
   localparam int PRIO_CAP2 = 0;
   localparam int UNIMPL_BIT = 5;

   localparam int RC_PLEN = 7;
   localparam int RC_SWBO = 6;
   localparam int RC_RINS = 4;
   localparam int RC_WDX = 3;
   localparam int RC_PWDN = 2;
   localparam int RC_POR = 1;
   localparam int RC_BOR = 0;

   localparam logic [7:0] PRIO_WMASK = 8'hdf;
   localparam logic [7:0] PRIO_RST = 8'hdf;
   localparam logic [7:0] RC_WMASK = 8'hd3;
   localparam logic [7:0] RC_RST = 8'h5c;

   localparam int EV_RINS = 0;
   localparam int EV_WDX = 1;
   localparam int EV_PWDN = 2;
   localparam int EV_POR = 3;
   localparam int EV_BOR = 4;
   localparam logic [4:0] IRQ_STAT_RST = 5'h00;
   localparam logic [4:0] IRQ_MASK_RST = 5'h00;

   // synchronised strap level settles at edge 4, so load at edge 5
   localparam logic [2:0] STRAP_SETTLE = 3'h4;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } irqprs_bus_s;

   typedef struct packed {
      logic reset_instr;
      logic wdt_timeout;
      logic wdt_clear;
      logic sleep_entry;
      logic brownout;
      logic poweron;
   } irqprs_evt_s;

   typedef enum logic [1:0] {
      ST_SETTLE = 2'b01,
      ST_RUN = 2'b10
   } irqprs_state_e;
endpackage

// ==== logic/irqprs_sync.sv ====
// three-stage synchroniser for a pin level, change taken when stages agree
`timescale 1ns/10ps
module irqprs_sync
(
   input wire logic clock,
   input wire logic rst,
   input wire logic pin,
   output logic level
);
   logic meta_r;
   logic s2_r;
   logic s3_r;
   logic level_r;
   wire agree = (s2_r == s3_r);

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         meta_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         level_r <= 1'b0;
      end
      else
      begin
         meta_r <= pin;
         s2_r <= meta_r;
         s3_r <= s2_r;
         if (agree)
            level_r <= s3_r;
      end
   end

   assign level = level_r;
endmodule

// ==== logic/irqprs_irq.sv ====
// sticky event status, read-to-clear, masked onto one level interrupt
`timescale 1ns/10ps
module irqprs_irq
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [4:0] events,
   input wire logic stat_rd,
   input wire logic mask_wr,
   input wire logic [4:0] mask_wdata,
   output logic [4:0] status,
   output logic [4:0] mask,
   output logic irq
);
   logic [4:0] stat_r;
   logic [4:0] mask_r;
   logic irq_r;
   // a new event in the read cycle survives the clear
   wire [4:0] stat_nxt = (stat_rd ? 5'h00 : stat_r) | events;
   wire [4:0] mask_nxt = mask_wr ? mask_wdata : mask_r;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         stat_r <= irqprs_pkg::IRQ_STAT_RST;
         mask_r <= irqprs_pkg::IRQ_MASK_RST;
         irq_r <= 1'b0;
      end
      else
      begin
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         irq_r <= |(stat_nxt & mask_nxt);
      end
   end

   assign status = stat_r;
   assign mask = mask_r;
   assign irq = irq_r;
endmodule

// ==== logic/irqprs_top.sv ====
// priority register group 2 and reset control/status register
`timescale 1ns/10ps
module irqprs_top
(
   input wire logic clock,
   input wire logic rst,
   input irqprs_pkg::irqprs_bus_s bus,
   output logic [7:0] rdata,
   input irqprs_pkg::irqprs_evt_s evt,
   input wire logic strap_swbo_default,
   input wire logic strap_reset_was_poweron,
   output logic [6:0] prio_high,
   output logic priority_levels_enable,
   output logic software_brownout_enable,
   output logic legacy_single_level,
   output logic irq
);

   // masked write of a register: unwritable bits keep old value
   function automatic logic [7:0] f_mwrite
   (
      input logic [7:0] old,
      input logic [7:0] wdata,
      input logic [7:0] wmask
   );
      f_mwrite = (old & ~wmask) | (wdata & wmask);
   endfunction

   // address hit for a strobe
   function automatic logic f_hit
   (
      input logic strobe,
      input logic [3:0] addr,
      input logic [3:0] off
   );
      f_hit = strobe & (addr == off);
   endfunction

   // ------------------------------------------------------------------
   // pin straps pass the three-stage synchroniser
   logic swbo_strap;
   logic poweron_strap;

   irqprs_sync u_sync_swbo
   (
      .clock(clock),
      .rst(rst),
      .pin(strap_swbo_default),
      .level(swbo_strap)
   );

   irqprs_sync u_sync_por
   (
      .clock(clock),
      .rst(rst),
      .pin(strap_reset_was_poweron),
      .level(poweron_strap)
   );

   // ------------------------------------------------------------------
   // strap capture after release: async reset only loads constants
   irqprs_pkg::irqprs_state_e state_r;
   irqprs_pkg::irqprs_state_e state_nxt;
   logic [2:0] settle_r;
   logic [2:0] settle_nxt;

   wire settle_done = (settle_r == irqprs_pkg::STRAP_SETTLE);
   wire strap_load = (state_r == irqprs_pkg::ST_SETTLE) & settle_done;

   always_comb
   begin
      state_nxt = state_r;
      settle_nxt = settle_r;
      unique case (state_r)
         irqprs_pkg::ST_SETTLE:
         begin
            if (settle_done)
               state_nxt = irqprs_pkg::ST_RUN;
            else
               settle_nxt = settle_r + 3'h1;
         end
         irqprs_pkg::ST_RUN:
         begin
            state_nxt = irqprs_pkg::ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_r <= irqprs_pkg::ST_SETTLE;
         settle_r <= 3'h0;
      end
      else
      begin
         state_r <= state_nxt;
         settle_r <= settle_nxt;
      end
   end

   // ------------------------------------------------------------------
   // bus decode
   wire wr_prio = f_hit(bus.wr, bus.addr, irqprs_pkg::OFF_PRIO);
   wire wr_rstc = f_hit(bus.wr, bus.addr, irqprs_pkg::OFF_RSTC);
   wire wr_mask = f_hit(bus.wr, bus.addr, irqprs_pkg::OFF_IRQ_MASK);
   wire rd_prio = f_hit(bus.rd, bus.addr, irqprs_pkg::OFF_PRIO);
   wire rd_rstc = f_hit(bus.rd, bus.addr, irqprs_pkg::OFF_RSTC);
   wire rd_stat = f_hit(bus.rd, bus.addr, irqprs_pkg::OFF_IRQ_STAT);
   wire rd_mask = f_hit(bus.rd, bus.addr, irqprs_pkg::OFF_IRQ_MASK);

   // ------------------------------------------------------------------
   // priority register group 2
   logic [7:0] prio_r;
   // bit 5 never written, so it stays zero
   wire [7:0] prio_nxt = wr_prio ?
      f_mwrite(prio_r, bus.wdata, irqprs_pkg::PRIO_WMASK) : prio_r;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         prio_r <= irqprs_pkg::PRIO_RST;
      else
         prio_r <= prio_nxt;
   end

   // ------------------------------------------------------------------
   // reset control and status register
   logic [7:0] rstc_r;
   logic [7:0] rstc_sw;
   logic [7:0] rstc_nxt;

   // software side: only the writable fields move, bit 5 stays zero
   assign rstc_sw = wr_rstc ?
      f_mwrite(rstc_r, bus.wdata, irqprs_pkg::RC_WMASK) : rstc_r;

   // hardware cause flags win over a software write in the same cycle
   always_comb
   begin
      rstc_nxt = rstc_sw;
      if (strap_load)
      begin
         rstc_nxt[irqprs_pkg::RC_SWBO] = swbo_strap;
         rstc_nxt[irqprs_pkg::RC_POR] = ~poweron_strap;
      end
      if (evt.reset_instr)
         rstc_nxt[irqprs_pkg::RC_RINS] = 1'b0;
      if (evt.wdt_clear)
      begin
         rstc_nxt[irqprs_pkg::RC_WDX] = 1'b1;
         rstc_nxt[irqprs_pkg::RC_PWDN] = 1'b1;
      end
      if (evt.wdt_timeout)
         rstc_nxt[irqprs_pkg::RC_WDX] = 1'b0;
      if (evt.sleep_entry)
         rstc_nxt[irqprs_pkg::RC_PWDN] = 1'b0;
      if (evt.poweron)
         rstc_nxt[irqprs_pkg::RC_POR] = 1'b0;
      if (evt.brownout)
         rstc_nxt[irqprs_pkg::RC_BOR] = 1'b0;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         rstc_r <= irqprs_pkg::RC_RST;
      else
         rstc_r <= rstc_nxt;
   end

   wire plen = rstc_r[irqprs_pkg::RC_PLEN];

   // ------------------------------------------------------------------
   // event status and interrupt
   logic [4:0] ev_vec;
   logic [4:0] irq_status;
   logic [4:0] irq_mask;
   logic irq_w;

   assign ev_vec[irqprs_pkg::EV_RINS] = evt.reset_instr;
   assign ev_vec[irqprs_pkg::EV_WDX] = evt.wdt_timeout;
   assign ev_vec[irqprs_pkg::EV_PWDN] = evt.sleep_entry;
   assign ev_vec[irqprs_pkg::EV_POR] = evt.poweron;
   assign ev_vec[irqprs_pkg::EV_BOR] = evt.brownout;

   irqprs_irq u_irq
   (
      .clock(clock),
      .rst(rst),
      .events(ev_vec),
      .stat_rd(rd_stat),
      .mask_wr(wr_mask),
      .mask_wdata(bus.wdata[4:0]),
      .status(irq_status),
      .mask(irq_mask),
      .irq(irq_w)
   );

   // ------------------------------------------------------------------
   // qualified priority levels for the arbiter
   logic [6:0] src_prio;

   assign src_prio = {
      prio_r[irqprs_pkg::PRIO_OSCF],
      prio_r[irqprs_pkg::PRIO_CMP],
      prio_r[irqprs_pkg::PRIO_NVM],
      prio_r[irqprs_pkg::PRIO_BCOL],
      prio_r[irqprs_pkg::PRIO_VDET],
      prio_r[irqprs_pkg::PRIO_TMR3],
      prio_r[irqprs_pkg::PRIO_CAP2]
   };

   // in single-level mode every source reads as low priority
   wire [6:0] prio_high_nxt = src_prio & {7{plen}};

   logic [6:0] prio_high_r;
   logic plen_out_r;
   logic legacy_r;
   logic swbo_out_r;

   // registered one cycle so the arbiter sees a clean level
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         prio_high_r <= 7'h00;
         plen_out_r <= 1'b0;
         legacy_r <= 1'b1;
         swbo_out_r <= 1'b0;
      end
      else
      begin
         prio_high_r <= prio_high_nxt;
         plen_out_r <= plen;
         legacy_r <= ~plen;
         swbo_out_r <= rstc_r[irqprs_pkg::RC_SWBO];
      end
   end

   // ------------------------------------------------------------------
   // read data, one cycle after the strobe; unmapped reads zero
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   always_comb
   begin
      rdata_nxt = 8'h00;
      if (rd_prio)
         rdata_nxt = prio_r;
      else if (rd_rstc)
         rdata_nxt = rstc_r;
      else if (rd_stat)
         rdata_nxt = {3'h0, irq_status};
      else if (rd_mask)
         rdata_nxt = {3'h0, irq_mask};
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         rdata_r <= 8'h00;
      else
         rdata_r <= rdata_nxt;
   end

   // ------------------------------------------------------------------
   // outputs
   assign rdata = rdata_r;
   assign prio_high = prio_high_r;
   assign priority_levels_enable = plen_out_r;
   assign legacy_single_level = legacy_r;
   assign software_brownout_enable = swbo_out_r;
   assign irq = irq_w;

endmodule

// ==== tb/irqprs_top_asserts.sv ====
// concurrent checks on the ports of the priority and reset status block
`timescale 1ns/10ps
module irqprs_chk
(
   input wire logic clock,
   input wire logic rst,
   input irqprs_pkg::irqprs_bus_s bus,
   input wire logic [7:0] rdata,
   input irqprs_pkg::irqprs_evt_s evt,
   input wire logic strap_swbo_default,
   input wire logic strap_reset_was_poweron,
   input wire logic [6:0] prio_high,
   input wire logic priority_levels_enable,
   input wire logic software_brownout_enable,
   input wire logic legacy_single_level,
   input wire logic irq
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence rstc_wr_s;
      bus.wr && bus.addr == irqprs_pkg::OFF_RSTC;
   endsequence

   // enable must hold over the whole update, or the output is ambiguous
   sequence prio_wr_s;
      (bus.wr && bus.addr == irqprs_pkg::OFF_PRIO && priority_levels_enable)
         ##1 (priority_levels_enable && !bus.wr);
   endsequence

   legacy_inverse_a:
      assert property (legacy_single_level == !priority_levels_enable)
         else $error("legacy flag not inverse of priority enable");
   prio_gated_a:
      assert property (!priority_levels_enable && !$past(priority_levels_enable)
         |-> prio_high == 7'h00)
         else $error("priority output set while levels disabled");
   rdata_idle_a:
      assert property (!$past(bus.rd) |-> rdata == 8'h00)
         else $error("read data outside read answer");
   unimpl_bit_a:
      assert property ($past(bus.rd) |-> rdata[5] == 1'b0)
         else $error("unimplemented bit read as one");
   unmapped_read_a:
      assert property ($past(bus.rd) && $past(bus.addr) > 4'h3
         |-> rdata == 8'h00)
         else $error("unmapped read not zero");
   software_brownout_enable_copy_a:
      assert property (rstc_wr_s |-> ##2
         software_brownout_enable == $past(bus.wdata[6], 2))
         else $error("brown-out enable not taken from write");
   priority_levels_enable_copy_a:
      assert property (rstc_wr_s |-> ##2
         priority_levels_enable == $past(bus.wdata[7], 2))
         else $error("priority enable not taken from write");
   prio_follow_a:
      assert property (prio_wr_s |-> ##1 prio_high ==
         {$past(bus.wdata[7:6], 2), $past(bus.wdata[4:0], 2)})
         else $error("priority output does not follow write");
   irq_clear_a:
      assert property (bus.rd && bus.addr == irqprs_pkg::OFF_IRQ_STAT
         && evt == '0 |=> !irq)
         else $error("interrupt stays after status read");
endmodule
bind irqprs_top irqprs_chk u_irqprs_chk (.*);

// ==== tb/irqprs_tb.sv ====
// self-checking bench for the priority and reset status block
`timescale 1ns/10ps
module testbench;
   logic clock;
   logic rst;
   irqprs_pkg::irqprs_bus_s bus;
   irqprs_pkg::irqprs_evt_s evt;
   logic strap_sb;
   logic strap_po;
   logic [7:0] rdata;
   logic [6:0] prio_high;
   logic ple;
   logic sbe;
   logic legacy;
   logic irq;
   int num_errors;
   int n_compared;

   irqprs_top u_irqprs_top (.clock(clock), .rst(rst), .bus(bus),
      .rdata(rdata), .evt(evt), .strap_swbo_default(strap_sb),
      .strap_reset_was_poweron(strap_po), .prio_high(prio_high),
      .priority_levels_enable(ple), .software_brownout_enable(sbe),
      .legacy_single_level(legacy), .irq(irq));

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task finish_test();
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task check(input string name, input logic [7:0] seen,
      input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task do_reset(input logic sb, input logic po);
      strap_sb <= sb;
      strap_po <= po;
      rst <= 1'b1;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      // straps land five edges after release
      repeat (6) @(posedge clock);
   endtask

   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus.wr <= 1'b0;
   endtask

   task rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask

   task t_reset_values();
      logic [7:0] d;
      do_reset(1'b1, 1'b1);
      rd(irqprs_pkg::OFF_PRIO, d);
      check("prio reset", d, 8'hdf);
      rd(irqprs_pkg::OFF_RSTC, d);
      check("rstc reset", d, 8'h5c);
      check("legacy", {7'h00, legacy}, 8'h01);
      check("plen reset", {7'h00, ple}, 8'h00);
      check("swbo out", {7'h00, sbe}, 8'h01);
      do_reset(1'b0, 1'b0);
      rd(irqprs_pkg::OFF_RSTC, d);
      check("rstc strap", d, 8'h1e);
      check("swbo low", {7'h00, sbe}, 8'h00);
   endtask

   task t_priority();
      logic [7:0] d;
      logic [7:0] p;
      wr(irqprs_pkg::OFF_RSTC, 8'hff);
      rd(irqprs_pkg::OFF_RSTC, d);
      check("rstc rw", d, 8'hdf);
      check("plen on", {7'h00, ple}, 8'h01);
      check("legacy off", {7'h00, legacy}, 8'h00);
      for (int i = 0; i < 10; i++)
      begin
         p = (i < 8) ? 8'h01 << i : (i == 8 ? 8'hff : 8'h00);
         wr(irqprs_pkg::OFF_PRIO, p);
         rd(irqprs_pkg::OFF_PRIO, d);
         check("prio rw", d, p & 8'hdf);
         check("prio out", {1'b0, prio_high}, {1'b0, p[7:6], p[4:0]});
      end
      wr(irqprs_pkg::OFF_PRIO, 8'hff);
      wr(irqprs_pkg::OFF_RSTC, 8'h00);
      rd(irqprs_pkg::OFF_RSTC, d);
      check("rstc ro", d, 8'h0c);
      repeat (2) @(posedge clock);
      check("prio gated", {1'b0, prio_high}, 8'h00);
      check("legacy on", {7'h00, legacy}, 8'h01);
   endtask

   // one event pulse, then the interrupt, the status and the flag
   task pulse(input logic [5:0] e, input logic [7:0] st,
      input logic [7:0] rc, input logic masked);
      logic [7:0] d;
      @(posedge clock);
      evt <= irqprs_pkg::irqprs_evt_s'(e);
      @(posedge clock);
      evt <= '0;
      #1 check("irq up", {7'h00, irq}, {7'h00, st != 0 && !masked});
      rd(irqprs_pkg::OFF_IRQ_STAT, d);
      check("status", d, st);
      check("irq down", {7'h00, irq}, 8'h00);
      rd(irqprs_pkg::OFF_RSTC, d);
      check("rstc flag", d, rc);
   endtask

   task t_events();
      logic [7:0] d;
      wr(irqprs_pkg::OFF_IRQ_MASK, 8'h1f);
      wr(irqprs_pkg::OFF_RSTC, 8'hd3);
      pulse(6'h20, 8'h01, 8'hcf, 1'b0);
      pulse(6'h10, 8'h02, 8'hc7, 1'b0);
      pulse(6'h04, 8'h04, 8'hc3, 1'b0);
      pulse(6'h08, 8'h00, 8'hcf, 1'b0);
      pulse(6'h01, 8'h08, 8'hcd, 1'b0);
      pulse(6'h02, 8'h10, 8'hcc, 1'b0);
      wr(irqprs_pkg::OFF_IRQ_MASK, 8'h00);
      pulse(6'h02, 8'h10, 8'hcc, 1'b1);
      wr(4'h9, 8'h00);
      rd(4'h9, d);
      check("unmapped", d, 8'h00);
      rd(irqprs_pkg::OFF_PRIO, d);
      check("prio kept", d, 8'hdf);
   endtask

   initial
   begin
      num_errors = 0;
      n_compared = 0;
      rst = 1'b1;
      bus = '0;
      evt = '0;
      strap_sb = 1'b1;
      strap_po = 1'b1;
      t_reset_values();
      t_priority();
      t_events();
      finish_test();
   end

   // whole run is under two hundred cycles
   initial
   begin
      #100000;
      num_errors++;
      finish_test();
   end
endmodule
